// ---- core/cmd_pulse_params.svh ----
// offsets, field widths, reset values and timing counts of the command pulse front end
`ifndef CMD_PULSE_PARAMS_SVH
`define CMD_PULSE_PARAMS_SVH

`define ADDR_W 5
`define DATA_W 16

`define OFS_ENC_FACTOR_A 5'h00
`define OFS_ENC_FACTOR_B 5'h01
`define OFS_GEAR_NUM_FIRST 5'h02
`define OFS_GEAR_DEN 5'h03
`define OFS_GEAR_NUM_SECOND 5'h04
`define OFS_GEAR_NUM_THIRD 5'h05
`define OFS_GEAR_NUM_FOURTH 5'h06
`define OFS_INPUT_FILTER 5'h07
`define OFS_PULSE_FORMAT 5'h08
`define OFS_DIR_INVERT 5'h09
`define OFS_EDGE_LOGIC 5'h0a
`define OFS_SIGN_BYPASS 5'h0b
`define OFS_EXP_TIME 5'h0c
`define OFS_LIN_TIME 5'h0d
`define OFS_RATE_SELECT 5'h0e
`define OFS_PPR_LO 5'h10
`define OFS_PPR_HI 5'h11
`define OFS_POS_LO 5'h12
`define OFS_POS_HI 5'h13
`define OFS_IN_CNT_LO 5'h14
`define OFS_IN_CNT_HI 5'h15
`define OFS_STATUS 5'h16

`define GEAR_W 15
`define FILT_SET_W 5
`define EXP_TIME_W 10
`define LIN_TIME_W 9
`define EXP_TIME_MAX 10'h3e8
`define LIN_TIME_MAX 9'h100

`define RST_ENC_FACTOR_A 15'h2710
`define RST_ENC_FACTOR_B 15'h0001
`define RST_GEAR 15'h0001
`define RST_INPUT_FILTER 5'h01

`define CLK_PERIOD_NS 40
`define MS_NS 1000000
`define CYC_PER_MS_DEF (`MS_NS / `CLK_PERIOD_NS)
`define FILT_UNIT_NS 160
`define FILT_UNIT_CYC (`FILT_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ---- core/cmd_pulse_pkg.sv ----
// types shared by the command pulse front end
package cmd_pulse_pkg;

   typedef enum logic [1:0] {
      FMT_PULSE_DIR = 2'h0,
      FMT_FWD_REV = 2'h1,
      FMT_QUAD = 2'h2
   } pulse_fmt_e;

   typedef enum logic [1:0] {
      DIV_IDLE = 2'b01,
      DIV_RUN = 2'b10
   } div_state_e;

   typedef logic signed [23:0] backlog_t;

endpackage

// ---- core/cmd_pulse_gear.sv ----
// command pulse input: filter, decode, smoothing and electronic gear
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "cmd_pulse_params.svh"

////////////////////////////////////////////////////////////////////////////////
// noise filter: output follows input only after it has been stable long enough
module line_filter (
   input wire logic sys_clk, // system clock
   input wire logic resetn, // synchronous reset, low active
   input wire logic din, // raw line
   input wire logic [7:0] hold_cyc, // cycles of stability needed, at least one
   output logic dout // filtered line
);
   logic [7:0] cnt_ff;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cnt_ff <= 8'h00;
         dout <= 1'b0;
      end else if (din == dout) begin
         cnt_ff <= 8'h00;
      end else if (cnt_ff + 8'h01 >= hold_cyc) begin
         cnt_ff <= 8'h00;
         dout <= din;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - format 0 pulse plus sign, 1 forward and reverse trains, 2 quadrature
// - two-bit logic setting inverts pulse and sign lines independently, choosing counted edge
// - direction setting reverses the counting direction of decoded pulses
// - pulse and sign lines filtered, setting 0 to 31, larger means longer
// - default filter accepts 1000kHz; host keeps below the lower limit of larger settings
// - filter-mode bit bypasses filtering of the sign line only
// - exponential smoothing, time to reach 63.2% of command frequency, 0 to 1000 ms
// - smoothing delays but never loses pulses; time 0 passes pulses unsmoothed
// - linear smoothing ramps to full frequency over 0 to 256 ms; 0 disables
// - decoded pulse count multiplied by numerator over denominator into position command
// - four numerators and one denominator, each 1 to 32767, default 1
// - pulses per revolution is product of two factors, defaults 10000 and 1
// - rate-select bit set to 1 takes command from the high-speed pulse input
// - two gear-select inputs choose numerator, high input is msb, change any time
module cmd_pulse_gear #(
   parameter int CYC_PER_MS = `CYC_PER_MS_DEF // cycles in one millisecond
) (
   input wire logic sys_clk, // 25 MHz system clock
   input wire logic resetn, // synchronous reset, low active
   input wire logic [`ADDR_W-1:0] reg_addr, // register address
   input wire logic [`DATA_W-1:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [`DATA_W-1:0] reg_rdata, // read data, cycle after the strobe
   input wire logic pulse_line, // command pulse line, normal path
   input wire logic sign_line, // command sign line, normal path
   input wire logic pulse_line_fast, // command pulse line, high-speed path
   input wire logic sign_line_fast, // command sign line, high-speed path
   input wire logic gear_select_low, // gear numerator select, lsb
   input wire logic gear_select_high, // gear numerator select, msb
   output logic signed [31:0] pos_cmd, // position command in encoder units
   output logic pos_step, // one-cycle pulse when pos_cmd changes
   output logic pos_dir // direction of that change, 1 = up
);
   logic [`GEAR_W-1:0] encoder_factor_a_ff;
   logic [`GEAR_W-1:0] encoder_factor_b_ff;
   logic [`GEAR_W-1:0] gear_num_ff [4];
   logic [`GEAR_W-1:0] gear_denominator_ff;
   logic [`FILT_SET_W-1:0] input_filter_setting_ff;
   logic [1:0] pulse_format_select_ff;
   logic count_direction_invert_ff;
   logic [1:0] signal_edge_logic_ff;
   logic sign_filter_bypass_ff;
   logic [`EXP_TIME_W-1:0] exponential_smoothing_time_ff;
   logic [`LIN_TIME_W-1:0] linear_smoothing_time_ff;
   logic pulse_rate_select_ff;
   logic [29:0] ppr_ff;
   logic signed [31:0] in_cnt_ff;
   logic [`GEAR_W-1:0] wval;
   logic [1:0] num_idx;

   ////////////////////////////////////////////////////////////////////////////
   // settings
   always_comb begin
      wval = (reg_wdata[`GEAR_W-1:0] == 15'h0000) ? 15'h0001 : reg_wdata[`GEAR_W-1:0];
      num_idx = 2'h0;
      case (reg_addr)
         `OFS_GEAR_NUM_SECOND: num_idx = 2'h1;
         `OFS_GEAR_NUM_THIRD: num_idx = 2'h2;
         `OFS_GEAR_NUM_FOURTH: num_idx = 2'h3;
         default: num_idx = 2'h0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         encoder_factor_a_ff <= `RST_ENC_FACTOR_A;
         encoder_factor_b_ff <= `RST_ENC_FACTOR_B;
         gear_num_ff <= '{`RST_GEAR, `RST_GEAR, `RST_GEAR, `RST_GEAR};
         gear_denominator_ff <= `RST_GEAR;
         input_filter_setting_ff <= `RST_INPUT_FILTER;
         pulse_format_select_ff <= 2'h0;
         count_direction_invert_ff <= 1'b0;
         signal_edge_logic_ff <= 2'h0;
         sign_filter_bypass_ff <= 1'b0;
         exponential_smoothing_time_ff <= '0;
         linear_smoothing_time_ff <= '0;
         pulse_rate_select_ff <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            `OFS_ENC_FACTOR_A: encoder_factor_a_ff <= wval;
            `OFS_ENC_FACTOR_B: encoder_factor_b_ff <= wval;
            `OFS_GEAR_NUM_FIRST, `OFS_GEAR_NUM_SECOND, `OFS_GEAR_NUM_THIRD,
            `OFS_GEAR_NUM_FOURTH: gear_num_ff[num_idx] <= wval;
            `OFS_GEAR_DEN: gear_denominator_ff <= wval;
            `OFS_INPUT_FILTER: input_filter_setting_ff <= reg_wdata[`FILT_SET_W-1:0];
            `OFS_PULSE_FORMAT: pulse_format_select_ff <= (reg_wdata[1:0] == 2'h3) ? 2'h2 : reg_wdata[1:0];
            `OFS_DIR_INVERT: count_direction_invert_ff <= reg_wdata[0];
            `OFS_EDGE_LOGIC: signal_edge_logic_ff <= reg_wdata[1:0];
            `OFS_SIGN_BYPASS: sign_filter_bypass_ff <= reg_wdata[0];
            `OFS_EXP_TIME: exponential_smoothing_time_ff <= (reg_wdata > 16'(`EXP_TIME_MAX)) ?
               `EXP_TIME_MAX : reg_wdata[`EXP_TIME_W-1:0];
            `OFS_LIN_TIME: linear_smoothing_time_ff <= (reg_wdata > 16'(`LIN_TIME_MAX)) ?
               `LIN_TIME_MAX : reg_wdata[`LIN_TIME_W-1:0];
            `OFS_RATE_SELECT: pulse_rate_select_ff <= reg_wdata[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ppr_ff <= 30'h00002710;
      end else begin
         ppr_ff <= 30'(encoder_factor_a_ff * encoder_factor_b_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input path, filters and decoder
   logic raw_pulse, raw_sign, flt_pulse, flt_sign, line_a, line_b, a_d_ff, b_d_ff, a_prev, b_prev, sign_src;
   logic [7:0] hold_cyc;
   logic dec_step, dec_up;

   assign raw_pulse = pulse_rate_select_ff ? pulse_line_fast : pulse_line;
   assign raw_sign = pulse_rate_select_ff ? sign_line_fast : sign_line;
   // longer setting, longer stability window; 0 still needs one cycle
   assign hold_cyc = (input_filter_setting_ff == 5'h00) ? 8'h01 :
      8'(input_filter_setting_ff * `FILT_UNIT_CYC);

   line_filter u_pulse_filter (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .din(raw_pulse),
      .hold_cyc(hold_cyc),
      .dout(flt_pulse)
   );

   line_filter u_sign_filter (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .din(raw_sign),
      .hold_cyc(hold_cyc),
      .dout(flt_sign)
   );

   assign sign_src = sign_filter_bypass_ff ? raw_sign : flt_sign;
   assign line_a = flt_pulse ^ signal_edge_logic_ff[0];
   assign line_b = sign_src ^ signal_edge_logic_ff[1];
   // history kept before the logic setting, so changing it makes no false edge
   assign a_prev = a_d_ff ^ signal_edge_logic_ff[0];
   assign b_prev = b_d_ff ^ signal_edge_logic_ff[1];

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         a_d_ff <= 1'b0;
         b_d_ff <= 1'b0;
      end else begin
         a_d_ff <= flt_pulse;
         b_d_ff <= sign_src;
      end
   end

   always_comb begin
      dec_step = 1'b0;
      dec_up = 1'b0;
      case (cmd_pulse_pkg::pulse_fmt_e'(pulse_format_select_ff))
         cmd_pulse_pkg::FMT_PULSE_DIR: begin
            dec_step = line_a & ~a_prev;
            dec_up = line_b;
         end
         cmd_pulse_pkg::FMT_FWD_REV: begin
            dec_step = (line_a & ~a_prev) ^ (line_b & ~b_prev);
            dec_up = line_a & ~a_prev;
         end
         cmd_pulse_pkg::FMT_QUAD: begin
            dec_step = (line_a ^ a_prev) ^ (line_b ^ b_prev);
            dec_up = line_a ^ b_prev;
         end
         default: begin
            dec_step = 1'b0;
            dec_up = 1'b0;
         end
      endcase
      dec_up = dec_up ^ count_direction_invert_ff;
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         in_cnt_ff <= '0;
      end else if (dec_step) begin
         in_cnt_ff <= dec_up ? in_cnt_ff + 32'sd1 : in_cnt_ff - 32'sd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // millisecond enable
   logic [24:0] ms_cnt_ff;
   logic ms_tick;

   assign ms_tick = (ms_cnt_ff == 25'(CYC_PER_MS - 1));

   always_ff @(posedge sys_clk) begin
      if (!resetn || ms_tick) begin
         ms_cnt_ff <= '0;
      end else begin
         ms_cnt_ff <= ms_cnt_ff + 25'h0000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // exponential smoothing: output rate = backlog / time constant
   cmd_pulse_pkg::backlog_t exp_bl_ff;
   logic [31:0] exp_ph_ff, exp_thr, exp_mag, exp_sum;
   logic exp_emit, exp_up;

   assign exp_thr = 32'(exponential_smoothing_time_ff) * 32'(CYC_PER_MS);
   assign exp_mag = 32'(exp_bl_ff[23] ? -exp_bl_ff : exp_bl_ff);
   assign exp_sum = exp_ph_ff + exp_mag;
   assign exp_up = ~exp_bl_ff[23];
   // a backlog always drains, so nothing is dropped
   assign exp_emit = (exp_bl_ff != 24'sd0) && ((exp_thr == 32'h0) || (exp_sum >= exp_thr));

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         exp_bl_ff <= '0;
         exp_ph_ff <= '0;
      end else begin
         exp_bl_ff <= exp_bl_ff + (dec_step ? (dec_up ? 24'sd1 : -24'sd1) : 24'sd0)
            - (exp_emit ? (exp_up ? 24'sd1 : -24'sd1) : 24'sd0);
         if (exp_thr == 32'h0) begin
            exp_ph_ff <= '0;
         end else if (exp_emit) begin
            exp_ph_ff <= exp_sum - exp_thr;
         end else if (exp_bl_ff != 24'sd0) begin
            exp_ph_ff <= exp_sum;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // linear smoothing: moving average of input steps over the window
   logic signed [11:0] bin_ff;
   logic signed [11:0] ring_ff [256];
   logic [7:0] wptr_ff, rptr;
   logic signed [19:0] lsum_ff;
   cmd_pulse_pkg::backlog_t lin_bl_ff;
   logic [31:0] lin_ph_ff, lin_thr, lin_mag, lin_sum;
   logic lin_clr, lin_emit, lin_up;

   assign lin_clr = reg_wr && (reg_addr == `OFS_LIN_TIME);
   assign rptr = wptr_ff - 8'(linear_smoothing_time_ff);
   assign lin_thr = 32'(linear_smoothing_time_ff) * 32'(CYC_PER_MS);
   assign lin_mag = 32'(lsum_ff[19] ? -lsum_ff : lsum_ff);
   assign lin_sum = lin_ph_ff + lin_mag;
   assign lin_up = ~lin_bl_ff[23];
   // empty window with leftover backlog flushes it
   assign lin_emit = (lin_bl_ff != 24'sd0) &&
      ((lin_thr == 32'h0) || (lsum_ff == 20'sd0) || (lin_sum >= lin_thr));

   always_ff @(posedge sys_clk) begin
      if (!resetn || lin_clr) begin
         bin_ff <= '0;
         wptr_ff <= '0;
         lsum_ff <= '0;
      end else if (ms_tick) begin
         bin_ff <= exp_emit ? (exp_up ? 12'sd1 : -12'sd1) : 12'sd0;
         wptr_ff <= wptr_ff + 8'h01;
         lsum_ff <= lsum_ff + 20'(bin_ff) - 20'(ring_ff[rptr]);
      end else if (exp_emit) begin
         bin_ff <= exp_up ? bin_ff + 12'sd1 : bin_ff - 12'sd1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn || lin_clr) begin
         for (int i = 0; i < 256; i++) begin
            ring_ff[i] <= '0;
         end
      end else if (ms_tick) begin
         ring_ff[wptr_ff] <= bin_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         lin_bl_ff <= '0;
         lin_ph_ff <= '0;
      end else begin
         lin_bl_ff <= lin_bl_ff + (exp_emit ? (exp_up ? 24'sd1 : -24'sd1) : 24'sd0)
            - (lin_emit ? (lin_up ? 24'sd1 : -24'sd1) : 24'sd0);
         if (lin_thr == 32'h0) begin
            lin_ph_ff <= '0;
         end else if (lin_emit) begin
            lin_ph_ff <= (lin_sum >= lin_thr) ? lin_sum - lin_thr : '0;
         end else if (lin_bl_ff != 24'sd0) begin
            lin_ph_ff <= lin_sum;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gear ratio: numerator / denominator split into quotient and remainder
   cmd_pulse_pkg::div_state_e div_st_ff;
   logic [`GEAR_W-1:0] num_sel, num_used_ff, den_used_ff, div_quo_ff, div_q_ff, div_r_ff;
   logic [15:0] div_rem_ff, rem_sh;
   logic [3:0] div_cnt_ff;
   logic gear_change;

   assign num_sel = gear_num_ff[{gear_select_high, gear_select_low}];
   assign gear_change = (num_sel != num_used_ff) || (gear_denominator_ff != den_used_ff);
   assign rem_sh = {div_rem_ff[14:0], div_quo_ff[`GEAR_W-1]};

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         div_st_ff <= cmd_pulse_pkg::DIV_IDLE;
         num_used_ff <= `RST_GEAR;
         den_used_ff <= `RST_GEAR;
         div_quo_ff <= '0;
         div_rem_ff <= '0;
         div_cnt_ff <= '0;
         div_q_ff <= `RST_GEAR;
         div_r_ff <= '0;
      end else begin
         case (div_st_ff)
            cmd_pulse_pkg::DIV_IDLE: begin
               if (gear_change) begin
                  num_used_ff <= num_sel;
                  den_used_ff <= gear_denominator_ff;
                  div_quo_ff <= num_sel;
                  div_rem_ff <= '0;
                  div_cnt_ff <= 4'(`GEAR_W);
                  div_st_ff <= cmd_pulse_pkg::DIV_RUN;
               end
            end
            cmd_pulse_pkg::DIV_RUN: begin
               if (rem_sh >= {1'b0, den_used_ff}) begin
                  div_rem_ff <= rem_sh - {1'b0, den_used_ff};
                  div_quo_ff <= {div_quo_ff[`GEAR_W-2:0], 1'b1};
               end else begin
                  div_rem_ff <= rem_sh;
                  div_quo_ff <= {div_quo_ff[`GEAR_W-2:0], 1'b0};
               end
               div_cnt_ff <= div_cnt_ff - 4'h1;
               if (div_cnt_ff == 4'h1) begin
                  div_st_ff <= cmd_pulse_pkg::DIV_IDLE;
                  div_q_ff <= (rem_sh >= {1'b0, den_used_ff}) ? {div_quo_ff[`GEAR_W-2:0], 1'b1} :
                     {div_quo_ff[`GEAR_W-2:0], 1'b0};
                  div_r_ff <= (rem_sh >= {1'b0, den_used_ff}) ? 15'(rem_sh - {1'b0, den_used_ff}) :
                     rem_sh[`GEAR_W-1:0];
               end
            end
            default: div_st_ff <= cmd_pulse_pkg::DIV_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // position accumulation with remainder carried between steps
   cmd_pulse_pkg::backlog_t g_bl_ff;
   logic signed [16:0] frac_ff, frac_nx;
   logic signed [31:0] pos_inc;
   logic g_ready, g_emit, g_up;

   assign g_ready = (div_st_ff == cmd_pulse_pkg::DIV_IDLE) && !gear_change;
   assign g_up = ~g_bl_ff[23];
   assign g_emit = g_ready && (g_bl_ff != 24'sd0);

   always_comb begin
      frac_nx = g_up ? frac_ff + 17'sd0 + 17'(div_r_ff) : frac_ff - 17'(div_r_ff);
      pos_inc = g_up ? 32'(div_q_ff) : -32'(div_q_ff);
      if (frac_nx >= $signed(17'(den_used_ff))) begin
         frac_nx = frac_nx - 17'(den_used_ff);
         pos_inc = pos_inc + 32'sd1;
      end else if (frac_nx < 17'sd0) begin
         frac_nx = frac_nx + 17'(den_used_ff);
         pos_inc = pos_inc - 32'sd1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         g_bl_ff <= '0;
         frac_ff <= '0;
         pos_cmd <= '0;
         pos_step <= 1'b0;
         pos_dir <= 1'b0;
      end else begin
         g_bl_ff <= g_bl_ff + (lin_emit ? (lin_up ? 24'sd1 : -24'sd1) : 24'sd0)
            - (g_emit ? (g_up ? 24'sd1 : -24'sd1) : 24'sd0);
         pos_step <= g_emit;
         if (g_emit) begin
            pos_dir <= g_up;
            frac_ff <= frac_nx;
            pos_cmd <= pos_cmd + pos_inc;
         end else if (gear_change && (gear_denominator_ff != den_used_ff)) begin
            frac_ff <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_ENC_FACTOR_A: reg_rdata <= {1'b0, encoder_factor_a_ff};
            `OFS_ENC_FACTOR_B: reg_rdata <= {1'b0, encoder_factor_b_ff};
            `OFS_GEAR_NUM_FIRST, `OFS_GEAR_NUM_SECOND, `OFS_GEAR_NUM_THIRD,
            `OFS_GEAR_NUM_FOURTH: reg_rdata <= {1'b0, gear_num_ff[num_idx]};
            `OFS_GEAR_DEN: reg_rdata <= {1'b0, gear_denominator_ff};
            `OFS_INPUT_FILTER: reg_rdata <= 16'(input_filter_setting_ff);
            `OFS_PULSE_FORMAT: reg_rdata <= 16'(pulse_format_select_ff);
            `OFS_DIR_INVERT: reg_rdata <= 16'(count_direction_invert_ff);
            `OFS_EDGE_LOGIC: reg_rdata <= 16'(signal_edge_logic_ff);
            `OFS_SIGN_BYPASS: reg_rdata <= 16'(sign_filter_bypass_ff);
            `OFS_EXP_TIME: reg_rdata <= 16'(exponential_smoothing_time_ff);
            `OFS_LIN_TIME: reg_rdata <= 16'(linear_smoothing_time_ff);
            `OFS_RATE_SELECT: reg_rdata <= 16'(pulse_rate_select_ff);
            `OFS_PPR_LO: reg_rdata <= ppr_ff[15:0];
            `OFS_PPR_HI: reg_rdata <= {2'h0, ppr_ff[29:16]};
            `OFS_POS_LO: reg_rdata <= pos_cmd[15:0];
            `OFS_POS_HI: reg_rdata <= pos_cmd[31:16];
            `OFS_IN_CNT_LO: reg_rdata <= in_cnt_ff[15:0];
            `OFS_IN_CNT_HI: reg_rdata <= in_cnt_ff[31:16];
            `OFS_STATUS: reg_rdata <= {13'h0000, (g_bl_ff != 24'sd0) || (lin_bl_ff != 24'sd0) ||
               (exp_bl_ff != 24'sd0), !g_ready, flt_pulse};
            default: reg_rdata <= '0;
         endcase
      end
   end

endmodule

// ---- sim/cmd_pulse_gear_asserts.sv ----
// port checker for the command pulse gear block
`timescale 1ns/1ps
`include "cmd_pulse_params.svh"
module cmd_pulse_gear_chk #(
   parameter int CYC_PER_MS = 25 // cycles in one millisecond
) (
   input wire logic sys_clk, // clock
   input wire logic resetn, // reset, low active
   input wire logic [`ADDR_W-1:0] reg_addr, // address
   input wire logic [`DATA_W-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [`DATA_W-1:0] reg_rdata, // read data
   input wire logic signed [31:0] pos_cmd, // position command
   input wire logic pos_step, // step pulse
   input wire logic pos_dir // step direction
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   reset_clear_a: assert property ($rose(resetn) |-> pos_cmd == 0 && !pos_step && !pos_dir && reg_rdata == 0)
      else $error("outputs not cleared by reset");
   step_only_a: assert property (!pos_step |-> $stable(pos_cmd))
      else $error("position moved without a step");
   step_dir_a: assert property (pos_step |-> (pos_dir ? pos_cmd >= $past(pos_cmd) : pos_cmd <= $past(pos_cmd)))
      else $error("position moved against its direction");
   unmapped_read_a: assert property (reg_rd && reg_addr == 5'h1f |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   gear_read_a: assert property (reg_wr && reg_addr == `OFS_GEAR_NUM_FIRST && !reg_wdata[15] && reg_wdata != 0
      ##1 reg_rd && reg_addr == `OFS_GEAR_NUM_FIRST |=> reg_rdata == $past(reg_wdata, 2))
      else $error("numerator readback wrong");
   fmt_clamp_a: assert property (reg_wr && reg_addr == `OFS_PULSE_FORMAT && reg_wdata == 16'h0003
      ##1 reg_rd && reg_addr == `OFS_PULSE_FORMAT |=> reg_rdata == 16'h0002)
      else $error("format not limited to two");
   exp_clamp_a: assert property (reg_wr && reg_addr == `OFS_EXP_TIME && reg_wdata == 16'h03ff
      ##1 reg_rd && reg_addr == `OFS_EXP_TIME |=> reg_rdata == 16'h03e8)
      else $error("smoothing time not limited");
   lin_clamp_a: assert property (reg_wr && reg_addr == `OFS_LIN_TIME && reg_wdata == 16'h01ff
      ##1 reg_rd && reg_addr == `OFS_LIN_TIME |=> reg_rdata == 16'h0100)
      else $error("ramp time not limited");
endmodule
bind cmd_pulse_gear cmd_pulse_gear_chk #(.CYC_PER_MS(CYC_PER_MS)) chk_inst (.sys_clk, .resetn, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pos_cmd, .pos_step, .pos_dir);

// ---- sim/pulse_host.sv ----
// host controller model driving command pulse trains
`timescale 1ns/1ps
module pulse_host (
   input wire logic sys_clk, // system clock
   output logic pulse_out, // command pulse line
   output logic sign_out // command sign line
);
   int gap = 16; // cycles per level, above filter hold plus two
   initial begin
      pulse_out = 1'b0;
      sign_out = 1'b0;
   end
   task automatic send(input logic [1:0] fmt, input logic up, input int n);
      logic sl;
      sl = fmt == 2'h1 && !up;
      for (int k = 0; k < n; k++) begin
         if (fmt == 2'h2) begin
            if ((pulse_out == sign_out) == up) pulse_out <= ~pulse_out;
            else sign_out <= ~sign_out;
         end else begin
            if (fmt == 2'h0) sign_out <= up;
            repeat (gap) @(posedge sys_clk);
            if (sl) sign_out <= 1'b1;
            else pulse_out <= 1'b1;
            repeat (gap) @(posedge sys_clk);
            if (sl) sign_out <= 1'b0;
            else pulse_out <= 1'b0;
         end
         repeat (gap) @(posedge sys_clk);
      end
      if (fmt != 2'h2) sign_out <= 1'b0;
      repeat (gap) @(posedge sys_clk);
   endtask
endmodule

// ---- sim/cmd_pulse_gear_tb.sv ----
// self-checking bench for the command pulse gear block
`timescale 1ns/1ps
module cmd_pulse_gear_tb;
   logic sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fast = 1'b0, rd_q = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [1:0] gsel = 2'h0;
   logic signed [31:0] pos_cmd, exp_pos = 0;
   logic pos_step, pos_dir, hp, hs;
   logic [31:0] rq[$], dq[$];
   int fails = 0, cmp_count = 0, r, in_sum = 0;
   int nm[4] = '{1, 2, 3, 1};
   logic [27:0] bt[24] = '{28'h0002710, 28'h0010001, 28'h0020001, 28'h0030001, 28'h0060001, 28'h0070001,
      28'h0102710, 28'h01f0000, 28'h1020007, 28'h0020007, 28'h1020001, 28'h1010003, 28'h0010003, 28'h0107530,
      28'h1080003, 28'h0080002, 28'h10c03ff, 28'h00c03e8, 28'h10d01ff, 28'h00d0100, 28'h10c0000, 28'h10d0000,
      28'h1040002, 28'h1050003};
   // scenario: register, value, format, host up, expected direction, count
   logic [27:0] sc[18] = '{28'h0800113, 28'h0800002, 28'h0811112, 28'h0811002, 28'h0822114, 28'h0822004,
      28'h0800111, 28'h0910102, 28'h0a20112, 28'h0900102, 28'h0a00111, 28'h0a10112, 28'h0730112, 28'h0700002,
      28'h0b10002, 28'h0c20113, 28'h0d20113, 28'h0e10112};
   wire pulse_line = fast ? 1'b0 : hp;
   wire sign_line = fast ? 1'b0 : hs;
   wire pulse_line_fast = fast ? hp : 1'b0;
   wire sign_line_fast = fast ? hs : 1'b0;
   wire gear_select_low = gsel[0];
   wire gear_select_high = gsel[1];
   always #20 sys_clk = ~sys_clk;
   cmd_pulse_gear #(.CYC_PER_MS(25)) cmd_pulse_gear_inst (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .pulse_line, .sign_line, .pulse_line_fast, .sign_line_fast, .gear_select_low,
      .gear_select_high, .pos_cmd, .pos_step, .pos_dir);
   pulse_host pulse_host_inst (.sys_clk, .pulse_out(hp), .sign_out(hs));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) rq.push_back({16'h0, d});
      @(posedge sys_clk);
   endtask
   task automatic idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge sys_clk);
   endtask
   // sends a train, then waits for every step and checks the total
   task automatic run(input logic [1:0] f, input logic u, input logic e, input int n, input int tot);
      int i;
      repeat (n) dq.push_back({31'h0, e});
      pulse_host_inst.send(f, u, n);
      exp_pos += e ? tot : -tot;
      in_sum += e ? n : -n;
      for (i = 0; i < 4000 && dq.size() != 0; i++) @(posedge sys_clk);
      chk(32'(dq.size()), 32'h0);
      repeat (3) @(posedge sys_clk);
      chk(pos_cmd, exp_pos);
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      if (rd_q) chk({16'h0, reg_rdata}, rq.pop_front());
      if (pos_step) chk({31'h0, pos_dir}, dq.size() != 0 ? dq.pop_front() : 32'hffffffff);
      rd_q <= reg_rd;
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      fails++;
      finish_test();
   end
   initial begin
      void'($urandom(32'hb3e4ac60));
      r = 1 + $urandom % 100;
      nm[3] = r;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      foreach (bt[i]) bus(bt[i][24], bt[i][20:16], bt[i][15:0]);
      bus(1'b1, 5'h06, r[15:0]);
      bus(1'b0, 5'h06, r[15:0]);
      foreach (sc[i]) begin
         bus(1'b1, sc[i][24:20], {12'h0, sc[i][19:16]});
         if (sc[i][24:20] == 5'h0e) fast <= 1'b1;
         idle();
         run(sc[i][13:12], sc[i][8], sc[i][4], int'(sc[i][3:0]), int'(sc[i][3:0]));
      end
      pulse_host_inst.gap = 8;
      foreach (nm[g]) begin
         gsel <= g[1:0];
         run(2'h0, 1'b1, 1'b1, 2, 2 * nm[g]);
      end
      bus(1'b1, 5'h03, 16'h0004);
      bus(1'b1, 5'h02, 16'h0005);
      idle();
      gsel <= 2'h0;
      run(2'h0, 1'b1, 1'b1, 4, 5);
      bus(1'b0, 5'h12, exp_pos[15:0]);
      bus(1'b0, 5'h13, exp_pos[31:16]);
      bus(1'b0, 5'h14, in_sum[15:0]);
      bus(1'b0, 5'h16, 16'h0000);
      idle();
      repeat (2) @(posedge sys_clk);
      finish_test();
   end
endmodule
